// ===== mic_top.sv
`timescale 1ns/1ns
`include "mic_map.svh"

module mic_top
	import mic_pkg::*;
#(
	parameter mic_byte_t IDENT_CODE = `MIC_IDENT_DEFAULT // Arbitrary value
)
(
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       sample_valid,
	input  wire logic [7:0] accel_x_mag,
	input  wire logic [7:0] accel_y_mag,
	input  wire logic [7:0] accel_z_mag,
	input  wire logic       gyro_event,
	input  wire logic       fifo_sample_count_event,
	input  wire logic       fifo_overflow,
	input  wire logic       fifo_level,
	input  wire logic       boot_status,
	input  wire logic       gyro_ready,
	input  wire logic       accel_ready,
	input  wire logic       gyro_inactivity,
	input  wire logic       accel_event2,
	input  wire logic       temp_ready,
	output logic            accel_event1,
	output logic            first_irq_pin,
	output logic            second_irq_pin,
	output logic      [7:0] gyro_hpf_ref,
	output logic      [2:0] gyro_output_rate,
	output logic      [1:0] gyro_full_scale,
	output logic      [1:0] gyro_bandwidth,
	output logic            irq
);

	mic_byte_t         thr_x_q, thr_y_q, thr_z_q, dur_q, ref_q;
	mic_byte_t         route1_q, route2_q, gctrl_q, rdata_q;
	logic [`MIC_EVT_W-1:0] evt_q, evt_en_q;
	mic_gen_state_t    gen_q;
	logic [6:0]        cnt_q;
	logic              pin1_q, pin2_q;
	mic_route_if       rt ();

	// Count reached: duration zero means immediate
	function automatic logic mic_reached(input logic [6:0] cnt, input logic [6:0] dur);
		mic_reached = ({1'b0, cnt} + 8'h01) >= {1'b0, dur};
	endfunction

	// Write decode
	wire wr_thr_x  = reg_wr && (reg_addr == `MIC_OFF_THR_X);
	wire wr_thr_y  = reg_wr && (reg_addr == `MIC_OFF_THR_Y);
	wire wr_thr_z  = reg_wr && (reg_addr == `MIC_OFF_THR_Z);
	wire wr_dur    = reg_wr && (reg_addr == `MIC_OFF_DURATION);
	wire wr_ref    = reg_wr && (reg_addr == `MIC_OFF_HPF_REF);
	wire wr_route1 = reg_wr && (reg_addr == `MIC_OFF_PIN1_ROUTE);
	wire wr_route2 = reg_wr && (reg_addr == `MIC_OFF_PIN2_ROUTE);
	wire wr_gctrl  = reg_wr && (reg_addr == `MIC_OFF_GYRO_CTRL1);
	wire wr_clear  = reg_wr && (reg_addr == `MIC_OFF_IRQ_CLEAR);
	wire wr_evt_en = reg_wr && (reg_addr == `MIC_OFF_IRQ_ENABLE);

	// Duration fields
	wire       exit_wait_enable     = dur_q[`MIC_DUR_WAIT_BIT];
	wire [6:0] event_duration_count = dur_q[`MIC_DUR_CNT_MSB:0];

	wire hit_x = accel_x_mag > thr_x_q;
	wire hit_y = accel_y_mag > thr_y_q;
	wire hit_z = accel_z_mag > thr_z_q;
	wire cond  = hit_x || hit_y || hit_z;

	wire [1:0] fs_wr  = reg_wdata[`MIC_G_FS_MSB:`MIC_G_FS_LSB];
	wire [1:0] fs_new = (fs_wr == `MIC_G_FS_UNAVAIL) ?
		gctrl_q[`MIC_G_FS_MSB:`MIC_G_FS_LSB] : fs_wr;
	wire mic_byte_t gctrl_d = {reg_wdata[`MIC_G_ODR_MSB:`MIC_G_ODR_LSB], fs_new, 1'b0,
		reg_wdata[`MIC_G_BW_MSB:`MIC_G_BW_LSB]};

	// Configuration registers; all reset to zero
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			thr_x_q <= `MIC_RST_BYTE;
			thr_y_q <= `MIC_RST_BYTE;
			thr_z_q <= `MIC_RST_BYTE;
			dur_q   <= `MIC_RST_BYTE;
			ref_q   <= `MIC_RST_BYTE;
		end
		else
		begin
			if (wr_thr_x) thr_x_q <= reg_wdata;
			if (wr_thr_y) thr_y_q <= reg_wdata;
			if (wr_thr_z) thr_z_q <= reg_wdata;
			if (wr_dur) dur_q <= reg_wdata;
			if (wr_ref) ref_q <= reg_wdata;
		end
	end

	// Routing and gyroscope control registers
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			route1_q <= `MIC_RST_BYTE;
			route2_q <= `MIC_RST_BYTE;
			gctrl_q  <= `MIC_RST_BYTE;
		end
		else
		begin
			if (wr_route1) route1_q <= reg_wdata;
			if (wr_route2) route2_q <= reg_wdata;
			if (wr_gctrl) gctrl_q <= gctrl_d;
		end
	end

	// Generator one next state; advances only on a new sample
	mic_gen_state_t gen_d;
	logic [6:0]     cnt_d;
	always_comb
	begin
		gen_d = gen_q;
		cnt_d = cnt_q;
		if (sample_valid)
		begin
			case (gen_q)
				MIC_G_IDLE:
				begin
					if (!cond)
						cnt_d = `MIC_RST_CNT;
					else if (mic_reached(cnt_q, event_duration_count))
					begin
						gen_d = MIC_G_ACTIVE;
						cnt_d = `MIC_RST_CNT;
					end
					else
						cnt_d = cnt_q + 7'h01;
				end
				MIC_G_ACTIVE:
				begin
					if (cond)
						cnt_d = `MIC_RST_CNT;
					else if (!exit_wait_enable || mic_reached(cnt_q, event_duration_count))
					begin
						gen_d = MIC_G_IDLE;
						cnt_d = `MIC_RST_CNT;
					end
					else
						cnt_d = cnt_q + 7'h01;
				end
				default:
				begin
					gen_d = MIC_G_IDLE;
					cnt_d = `MIC_RST_CNT;
				end
			endcase
		end
	end

	// Generator one state
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			gen_q <= MIC_G_IDLE;
			cnt_q <= `MIC_RST_CNT;
		end
		else
		begin
			gen_q <= gen_d;
			cnt_q <= cnt_d;
		end
	end

	// Source vectors in routing-register bit order
	// Pin1 sources, from gyro_event down to accel_ready
	assign rt.pin1_src = {gyro_event, accel_event1, fifo_sample_count_event, fifo_overflow,
		fifo_level, boot_status, gyro_ready, accel_ready};
	assign rt.pin2_src = {gyro_inactivity, accel_event2, fifo_sample_count_event,
		fifo_overflow, fifo_level, temp_ready, gyro_ready, accel_ready};
	assign rt.pin1_en  = route1_q;
	assign rt.pin2_en  = route2_q;

	mic_pin_route u_route (
		.rt (rt)
	);

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pin1_q <= 1'b0;
			pin2_q <= 1'b0;
		end
		else
		begin
			pin1_q <= rt.pin1_hit;
			pin2_q <= rt.pin2_hit;
		end
	end

	// Event capture; a set in the clear cycle wins
	wire [`MIC_EVT_W-1:0] evt_set = {rt.pin2_hit && !pin2_q, rt.pin1_hit && !pin1_q,
		(gen_q == MIC_G_ACTIVE) && (gen_d == MIC_G_IDLE),
		(gen_q == MIC_G_IDLE) && (gen_d == MIC_G_ACTIVE)};
	wire [`MIC_EVT_W-1:0] evt_clr = wr_clear ? reg_wdata[`MIC_EVT_W-1:0] : `MIC_RST_EVT;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			evt_q    <= `MIC_RST_EVT;
			evt_en_q <= `MIC_RST_EVT;
		end
		else
		begin
			evt_q <= (evt_q & ~evt_clr) | evt_set;
			if (wr_evt_en) evt_en_q <= reg_wdata[`MIC_EVT_W-1:0];
		end
	end

	// Read mux; unmapped and write-only offsets read zero
	mic_byte_t rd_mux;
	always_comb
	begin
		if (reg_addr == `MIC_OFF_THR_X)           rd_mux = thr_x_q;
		else if (reg_addr == `MIC_OFF_THR_Y)      rd_mux = thr_y_q;
		else if (reg_addr == `MIC_OFF_THR_Z)      rd_mux = thr_z_q;
		else if (reg_addr == `MIC_OFF_DURATION)   rd_mux = dur_q;
		else if (reg_addr == `MIC_OFF_HPF_REF)    rd_mux = ref_q;
		else if (reg_addr == `MIC_OFF_PIN1_ROUTE) rd_mux = route1_q;
		else if (reg_addr == `MIC_OFF_PIN2_ROUTE) rd_mux = route2_q;
		else if (reg_addr == `MIC_OFF_IDENTITY)   rd_mux = IDENT_CODE;
		else if (reg_addr == `MIC_OFF_GYRO_CTRL1) rd_mux = gctrl_q;
		else if (reg_addr == `MIC_OFF_IRQ_STATUS) rd_mux = {4'h0, evt_q};
		else if (reg_addr == `MIC_OFF_IRQ_ENABLE) rd_mux = {4'h0, evt_en_q};
		else                                      rd_mux = `MIC_RST_BYTE;
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n) rdata_q <= `MIC_RST_BYTE;
		else         rdata_q <= reg_rd ? rd_mux : `MIC_RST_BYTE;
	end

	// Outputs
	assign reg_rdata        = rdata_q;
	assign accel_event1     = (gen_q == MIC_G_ACTIVE);
	assign first_irq_pin    = pin1_q;
	assign second_irq_pin   = pin2_q;
	assign gyro_hpf_ref     = ref_q;
	assign gyro_output_rate = gctrl_q[`MIC_G_ODR_MSB:`MIC_G_ODR_LSB];
	assign gyro_full_scale  = gctrl_q[`MIC_G_FS_MSB:`MIC_G_FS_LSB];
	assign gyro_bandwidth   = gctrl_q[`MIC_G_BW_MSB:`MIC_G_BW_LSB];
	assign irq              = |(evt_q & evt_en_q);

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	sequence s_write_x;
		reg_wr && (reg_addr == `MIC_OFF_THR_X);
	endsequence
	sequence s_read_x;
		reg_rd && (reg_addr == `MIC_OFF_THR_X) && !reg_wr;
	endsequence

	a_x_thr_readback: assert property (
		s_write_x ##1 !reg_wr ##1 s_read_x |=> reg_rdata == $past(reg_wdata, 3))
		else $error("X threshold readback mismatch");

	a_y_thr_hold: assert property (
		$changed(thr_y_q) |-> $past(reg_wr) && ($past(reg_addr) == `MIC_OFF_THR_Y))
		else $error("Y threshold changed without a write");

	// A single Z sample above threshold enters at once when the duration is zero
	a_z_thr_cond: assert property (
		sample_valid && !accel_event1 && (accel_z_mag > thr_z_q) &&
		(event_duration_count == `MIC_RST_CNT) |=> accel_event1)
		else $error("Z threshold compare missed");

	a_enter_on_sample: assert property (
		$rose(accel_event1) |-> $past(sample_valid) && $past(cond))
		else $error("Generator entered without a qualifying sample");

	a_exit_no_wait: assert property (
		accel_event1 && !exit_wait_enable && sample_valid && !cond |=> !accel_event1)
		else $error("Generator exit delayed with wait off");

	a_ref_drive: assert property (
		wr_ref |=> gyro_hpf_ref == $past(reg_wdata) ##1 $stable(gyro_hpf_ref) || $past(wr_ref))
		else $error("Reference output wrong after write");

	a_pin1_route: assert property (
		##1 first_irq_pin == $past(|(rt.pin1_src & route1_q)))
		else $error("First pin does not match enabled sources");

	a_pin2_quiet: assert property (
		(route2_q == `MIC_RST_BYTE) [*2] |-> !second_irq_pin)
		else $error("Second pin active with routing off");

	a_ident_read: assert property (
		reg_rd && (reg_addr == `MIC_OFF_IDENTITY) |=> reg_rdata == IDENT_CODE)
		else $error("Identity read wrong");

	a_fs_refused: assert property (
		wr_gctrl && (fs_wr == `MIC_G_FS_UNAVAIL) |=> $stable(gyro_full_scale))
		else $error("Unavailable full-scale code accepted");

	a_evt_set_wins: assert property (
		evt_set[`MIC_EVT_ENTER] |=> evt_q[`MIC_EVT_ENTER])
		else $error("Enter event lost");

endmodule

// ===== mic_map.svh
`ifndef MIC_MAP_SVH
`define MIC_MAP_SVH

// Register offsets
`define MIC_OFF_THR_X      8'h07
`define MIC_OFF_THR_Y      8'h08
`define MIC_OFF_THR_Z      8'h09
`define MIC_OFF_DURATION   8'h0A
`define MIC_OFF_HPF_REF    8'h0B
`define MIC_OFF_PIN1_ROUTE 8'h0C
`define MIC_OFF_PIN2_ROUTE 8'h0D
`define MIC_OFF_IDENTITY   8'h0F
`define MIC_OFF_GYRO_CTRL1 8'h10
`define MIC_OFF_IRQ_STATUS 8'h20
`define MIC_OFF_IRQ_CLEAR  8'h21
`define MIC_OFF_IRQ_ENABLE 8'h22

// Reset values and fixed constants
`define MIC_RST_BYTE       8'h00
`define MIC_RST_CNT        7'h00
`define MIC_RST_EVT        4'h0
`define MIC_IDENT_DEFAULT  8'hA5

// Duration register fields
`define MIC_DUR_WAIT_BIT   7
`define MIC_DUR_CNT_MSB    6

// Gyroscope control fields
`define MIC_G_ODR_MSB      7
`define MIC_G_ODR_LSB      5
`define MIC_G_FS_MSB       4
`define MIC_G_FS_LSB       3
`define MIC_G_RSVD_BIT     2
`define MIC_G_BW_MSB       1
`define MIC_G_BW_LSB       0
`define MIC_G_FS_UNAVAIL   2'h2

// Event status bits
`define MIC_EVT_W          4
`define MIC_EVT_ENTER      0
`define MIC_EVT_EXIT       1
`define MIC_EVT_PIN1       2
`define MIC_EVT_PIN2       3

`endif

// ===== mic_pkg.sv
package mic_pkg;
	typedef logic [7:0] mic_byte_t;
	typedef enum logic {MIC_G_IDLE, MIC_G_ACTIVE} mic_gen_state_t;
endpackage

// ===== mic_route_if.sv
`timescale 1ns/1ns
// Routing sources, enables and per-pin result between top and router
interface mic_route_if;
	logic [7:0] pin1_src;
	logic [7:0] pin2_src;
	logic [7:0] pin1_en;
	logic [7:0] pin2_en;
	logic       pin1_hit;
	logic       pin2_hit;
	modport top    (output pin1_src, pin2_src, pin1_en, pin2_en, input pin1_hit, pin2_hit);
	modport router (input pin1_src, pin2_src, pin1_en, pin2_en, output pin1_hit, pin2_hit);
endinterface

// ===== mic_pin_route.sv
`timescale 1ns/1ns
module mic_pin_route
	import mic_pkg::*;
(
	mic_route_if.router rt
);

	// Any source that is both asserted and enabled
	function automatic logic mic_any_hit(input mic_byte_t src, input mic_byte_t en);
		mic_any_hit = |(src & en);
	endfunction

	assign rt.pin1_hit = mic_any_hit(rt.pin1_src, rt.pin1_en);
	assign rt.pin2_hit = mic_any_hit(rt.pin2_src, rt.pin2_en);

endmodule

// ===== mic_src_model.sv
`timescale 1ns/1ns
// Far-side source logic: turns one level vector into the block's event sources
module mic_src_model
(
	input  wire logic [9:0] lvl,
	output logic            accel_ready,
	output logic            gyro_ready,
	output logic            boot_status,
	output logic            fifo_level,
	output logic            fifo_overflow,
	output logic            fifo_sample_count_event,
	output logic            gyro_event,
	output logic            temp_ready,
	output logic            gyro_inactivity,
	output logic            accel_event2
);
	// Sources are plain levels; each one is held until the bench changes it
	assign accel_ready             = lvl[0];
	assign gyro_ready              = lvl[1];
	assign boot_status             = lvl[2];
	assign fifo_level              = lvl[3];
	assign fifo_overflow           = lvl[4];
	assign fifo_sample_count_event = lvl[5];
	assign gyro_event              = lvl[6];
	assign temp_ready              = lvl[7];
	assign gyro_inactivity         = lvl[8];
	assign accel_event2            = lvl[9];
endmodule

// ===== tb_top.sv
`timescale 1ns/1ns
module tb_top
	import mic_pkg::*;
;
	// Routing bit to level-vector (lvl) bit, per pin
	localparam int M1 [8] = '{0, 1, 2, 3, 4, 5, 0, 6};
	localparam int M2 [8] = '{0, 1, 7, 3, 4, 5, 9, 8};
	localparam int LIMIT  = 5000;
	logic       sys_clk, arst_n, reg_wr, reg_rd, sample_valid;
	logic [7:0] reg_addr, reg_wdata, mx, my, mz, reg_rdata, gyro_hpf_ref;
	logic [9:0] lvl;
	logic       a_rdy, g_rdy, boot, f_lvl, f_ovr, f_cnt, g_evt, t_rdy, g_ina, a_ev2;
	logic       accel_event1, first_irq_pin, second_irq_pin, irq;
	logic [2:0] gyro_output_rate;
	logic [1:0] gyro_full_scale, gyro_bandwidth;
	int         err_count, n_checks, cyc;

	// Clock at 100 ns period
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	mic_src_model u_mic_src_model (.lvl(lvl), .accel_ready(a_rdy), .gyro_ready(g_rdy),
		.boot_status(boot), .fifo_level(f_lvl), .fifo_overflow(f_ovr),
		.fifo_sample_count_event(f_cnt), .gyro_event(g_evt), .temp_ready(t_rdy),
		.gyro_inactivity(g_ina), .accel_event2(a_ev2));

	// Identity value is arbitrary, chosen apart from the default to prove the parameter
	mic_top #(.IDENT_CODE(8'h3C)) u_mic_top (.sys_clk(sys_clk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sample_valid(sample_valid), .accel_x_mag(mx),
		.accel_y_mag(my), .accel_z_mag(mz), .gyro_event(g_evt),
		.fifo_sample_count_event(f_cnt), .fifo_overflow(f_ovr), .fifo_level(f_lvl),
		.boot_status(boot), .gyro_ready(g_rdy), .accel_ready(a_rdy),
		.gyro_inactivity(g_ina), .accel_event2(a_ev2), .temp_ready(t_rdy),
		.accel_event1(accel_event1), .first_irq_pin(first_irq_pin),
		.second_irq_pin(second_irq_pin), .gyro_hpf_ref(gyro_hpf_ref),
		.gyro_output_rate(gyro_output_rate), .gyro_full_scale(gyro_full_scale),
		.gyro_bandwidth(gyro_bandwidth), .irq(irq));

	task automatic give_verdict();
		if (err_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Narrow results are zero-extended so one compare serves bytes and flags
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe, so it is taken there
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(nm, e, reg_rdata);
	endtask

	task automatic smp(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
		@(posedge sys_clk);
		mx           <= x;
		my           <= y;
		mz           <= z;
		sample_valid <= 1'b1;
		@(posedge sys_clk);
		sample_valid <= 1'b0;
		wt(2);
	endtask

	task automatic setl(input logic [9:0] v);
		@(posedge sys_clk);
		lvl <= v;
		wt(3);
	endtask

	// Hang guard: runs out well after the full sequence should have ended
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			err_count++;
			give_verdict();
		end
	end

	initial
	begin
		int k;
		logic [7:0] offs [7];
		offs = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
		{arst_n, reg_wr, reg_rd, sample_valid} = 4'h0;
		{reg_addr, reg_wdata, mx, my, mz} = '0;
		lvl = 10'h3FF;
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 7; i++) rd(offs[i], 8'h00, "reset value");
		rd(8'h10, 8'h00, "gyro ctrl reset");
		chk("pins idle", 8'h00, {first_irq_pin, second_irq_pin});
		// Each of the seven registers at 07..0D holds a distinct byte, all written before any readback
		for (int i = 0; i < 7; i++) wr(offs[i], 8'h5A ^ (8'h11 * i[7:0]));
		for (int i = 0; i < 7; i++) rd(offs[i], 8'h5A ^ (8'h11 * i[7:0]), "readback");
		chk("hpf output", 8'h1E, gyro_hpf_ref);
		wr(8'h0F, 8'h00);
		rd(8'h0F, 8'h3C, "identity");
		wr(8'h30, 8'hFF);
		rd(8'h30, 8'h00, "unmapped");
		rd(8'h21, 8'h00, "clear reg");
		wr(8'h10, 8'hFF);
		rd(8'h10, 8'hFB, "reserved bit");
		wr(8'h10, 8'h10);
		rd(8'h10, 8'h18, "fs code 10");
		wr(8'h10, 8'hE9);
		wt(1);
		chk("gyro fields", 8'hE9, {gyro_output_rate, gyro_full_scale, 1'b0, gyro_bandwidth});
		// Each route but pin1 bit 6 alone: all other sources high keep it low, its own source lifts it
		for (int p = 0; p < 2; p++)
			for (int i = 0; i < 8; i++)
				if (!(p == 0 && i == 6))
				begin
					k = (p != 0) ? M2[i] : M1[i];
					wr((p != 0) ? 8'h0D : 8'h0C, 8'h01 << i);
					wr((p != 0) ? 8'h0C : 8'h0D, 8'h00);
					setl(~(10'h001 << k));
					chk("pin others", 8'h00, {first_irq_pin, second_irq_pin});
					setl(10'h001 << k);
					chk("pin own", (p != 0) ? 8'h01 : 8'h02, {first_irq_pin, second_irq_pin});
				end
		setl(10'h000);
		// Generator 1: two samples to enter, strict compare, masked then enabled irq
		wr(8'h07, 8'h10);
		rd(8'h07, 8'h10, "x threshold");
		wr(8'h08, 8'h50);
		wr(8'h09, 8'h30);
		wr(8'h0A, 8'h02);
		wr(8'h0C, 8'h40);
		wr(8'h22, 8'h00);
		smp(8'h11, 8'h00, 8'h00);
		chk("one sample", 8'h00, accel_event1);
		smp(8'h11, 8'h00, 8'h00);
		chk("entered", 8'h01, accel_event1);
		wt(1);
		chk("pin1 gen", 8'h01, first_irq_pin);
		chk("irq masked", 8'h00, irq);
		wr(8'h22, 8'h01);
		wt(1);
		chk("irq on", 8'h01, irq);
		wr(8'h21, 8'h01);
		wt(1);
		chk("irq cleared", 8'h00, irq);
		// Pin rise events from the routing tests stay sticky; only the enter bit was cleared
		rd(8'h20, 8'h0C, "irq status");
		rd(8'h22, 8'h01, "irq enable");
		smp(8'h10, 8'h00, 8'h00);
		chk("exit no wait", 8'h00, accel_event1);
		// Exit wait on: one false sample is not enough to leave
		wr(8'h0A, 8'h82);
		smp(8'h00, 8'h51, 8'h00);
		smp(8'h00, 8'h51, 8'h00);
		chk("y entered", 8'h01, accel_event1);
		smp(8'h00, 8'h50, 8'h00);
		chk("wait hold", 8'h01, accel_event1);
		smp(8'h00, 8'h00, 8'h00);
		chk("wait exit", 8'h00, accel_event1);
		// Duration zero acts as a single sample on the Z axis
		wr(8'h0A, 8'h00);
		smp(8'h00, 8'h00, 8'h31);
		chk("z entered", 8'h01, accel_event1);
		smp(8'h00, 8'h00, 8'h30);
		chk("z exit", 8'h00, accel_event1);
		give_verdict();
	end
endmodule
